// ---- core/stepper_drive_control_fault.sv ----
// per-axis current, holding and fault supervision of a four-axis stepper drive
//
// Chosen here: the register offsets and the address-and-strobe port.
`include "stepper_drive_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module stepper_drive_control_fault
  import stepper_drive_pkg::*;
#(
  parameter int AXES = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic sample_tick_i,
  input wire logic [3:0] axis_moving_i,
  input wire logic thread0_running_i,
  input wire logic emergency_lockout_input_i,
  input wire logic [31:0] phase_current_da_i,
  input wire logic [9:0] supply_dv_i,
  output logic [3:0] amp_enable_o,
  output logic [3:0] hold_quarter_o,
  output logic [47:0] axis_current_ma_o,
  output logic handler_launch_o
);

  // ========================================================================
  // elaboration check
  if (AXES != 4) begin : g_axes_check
    $error("stepper_drive_control_fault serves exactly four axes");
  end

  // ========================================================================
  // reset release: two flops so deassertion is clean in this domain
  logic rst_m_q;
  logic rst_b_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_b_q <= rst_m_q;
    end
  end

  drive_state_t st_q;
  drive_state_t st_d;

  // ========================================================================
  // helpers
  function automatic logic [11:0] code_to_ma(input logic [1:0] code);
    logic [11:0] ma;
    ma = `SDC_CUR_CODE1_MA;
    case (code)
      2'h0: ma = `SDC_CUR_CODE0_MA;
      2'h1: ma = `SDC_CUR_CODE1_MA;
      2'h2: ma = `SDC_CUR_CODE2_MA;
      2'h3: ma = `SDC_CUR_CODE3_MA;
      default: ma = `SDC_CUR_CODE1_MA;
    endcase
    return ma;
  endfunction : code_to_ma

  logic [8:0] pair_sum [2];
  logic [1:0] pair_over;
  logic supply_low;
  logic cmd_disable;
  logic cmd_reenable;
  logic [3:0] hold_off;
  logic fault_any;

  // pair sums are 9 bits wide so two 8-bit readings cannot wrap
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pair_sum[p] = {1'b0, phase_current_da_i[16*p +: 8]} +
                    {1'b0, phase_current_da_i[16*p+8 +: 8]};
      pair_over[p] = pair_sum[p] > `SDC_OC_LIMIT_DA;
    end
    supply_low = supply_dv_i < `SDC_UV_LIMIT_DV;
    cmd_disable = reg_wr_i && (reg_addr_i == `SDC_OFF_CMD) &&
                  reg_wdata_i[`SDC_CMD_DISABLE_BIT];
    cmd_reenable = reg_wr_i && (reg_addr_i == `SDC_OFF_CMD) &&
                   reg_wdata_i[`SDC_CMD_REENABLE_BIT];
  end

  // ========================================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.launch = 1'b0;
    st_d.rdata = 16'h0000;

    // lockout pin: third flop must agree with second before it counts
    st_d.lk_s1 = emergency_lockout_input_i;
    st_d.lk_s2 = st_q.lk_s1;
    st_d.lk_s3 = st_q.lk_s2;
    if (st_q.lk_s2 == st_q.lk_s3) begin
      st_d.lk_filt = st_q.lk_s3;
    end

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SDC_OFF_CUR_SEL: st_d.cur_sel = reg_wdata_i[7:0];
        `SDC_OFF_MOTOR_TYPE: st_d.mtype = reg_wdata_i[3:0];
        `SDC_OFF_CTRL: st_d.handler_def = reg_wdata_i[`SDC_CTRL_HANDLER_BIT];
        default: ;
      endcase
      for (int a = 0; a < 4; a++) begin
        // writes to an axis not yet in stepper mode are dropped
        if (reg_addr_i == `SDC_OFF_HOLD0 + 4'(a) && st_q.mtype[a]) begin
          st_d.hold[a] = reg_wdata_i[14:0];
        end
      end
    end

    // lockout recovery: trip, then disable, then re-enable
    case (st_q.lk_state)
      LK_CLEAR: begin
        if (st_q.lk_filt) begin
          st_d.lk_state = LK_TRIPPED;
        end
      end
      LK_TRIPPED: begin
        if (cmd_disable) begin
          st_d.lk_state = LK_DISARMED;
        end
      end
      LK_DISARMED: begin
        if (cmd_reenable && !st_q.lk_filt) begin
          st_d.lk_state = LK_CLEAR;
        end
      end
      default: st_d.lk_state = LK_TRIPPED;
    endcase

    // motor-off state per axis
    if (cmd_reenable && st_d.lk_state == LK_CLEAR) begin
      st_d.axis_off = 4'h0;
    end
    if (cmd_disable || st_d.lk_state != LK_CLEAR) begin
      st_d.axis_off = 4'hf;
    end

    // over-current: sticky, cleared only by re-enable once current is gone
    for (int p = 0; p < 2; p++) begin
      if (cmd_reenable && !pair_over[p]) begin
        st_d.oc[p] = 1'b0;
      end
      if (pair_over[p]) begin
        st_d.oc[p] = 1'b1;
      end
    end

    // under-voltage follows the supply and needs no command
    st_d.uv = supply_low;

    // holding: count samples at rest, then full current, quarter current or amp off
    for (int a = 0; a < 4; a++) begin
      if (axis_moving_i[a]) begin
        st_d.idle_cnt[a] = 15'h0000;
      end else if (sample_tick_i && st_q.idle_cnt[a] < st_q.hold[a]) begin
        st_d.idle_cnt[a] = st_q.idle_cnt[a] + 15'h0001;
      end
      hold_off[a] = !axis_moving_i[a] && st_q.hold[a] >= 15'h0002 &&
                    st_d.idle_cnt[a] >= st_q.hold[a];
      st_d.quarter[a] = !axis_moving_i[a] && st_q.hold[a] == 15'h0001;
      st_d.cur_ma[a] = code_to_ma(st_d.cur_sel[2*a +: 2]);
      if (st_d.quarter[a]) begin
        st_d.cur_ma[a] = {2'b00, st_d.cur_ma[a][11:2]};
      end
      st_d.amp_en[a] = !st_d.axis_off[a] && !st_d.oc[a/2] && !st_d.uv &&
                       !hold_off[a];
    end

    // handler launch on a fresh fault while thread zero runs
    fault_any = st_d.lk_state != LK_CLEAR || (|st_d.oc) || st_d.uv;
    st_d.fault_prev = fault_any;
    if (fault_any && !st_q.fault_prev && st_q.handler_def && thread0_running_i) begin
      st_d.launch = 1'b1;
    end
    // power-up check stays armed until the supply is seen or the handler runs
    if (st_q.pwr_arm) begin
      if (!supply_low) begin
        st_d.pwr_arm = 1'b0;
      end else if (st_q.handler_def) begin
        st_d.launch = 1'b1;
        st_d.pwr_arm = 1'b0;
      end
    end

    // reads: pure observation, nothing is cleared here
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SDC_OFF_CUR_SEL: st_d.rdata = {8'h00, st_q.cur_sel};
        `SDC_OFF_MOTOR_TYPE: st_d.rdata = {12'h000, st_q.mtype};
        `SDC_OFF_CTRL: st_d.rdata = {15'h0000, st_q.handler_def};
        `SDC_OFF_QUERY0: st_d.rdata = {13'h0000, st_q.uv, st_q.oc};
        `SDC_OFF_QUERY3: begin
          st_d.rdata = (st_q.lk_state != LK_CLEAR) ? {8'h00, `SDC_LOCKOUT_CODE} :
                       16'h0000;
        end
        `SDC_OFF_STATUS: st_d.rdata = {8'h00, st_q.axis_off, st_q.amp_en};
        default: st_d.rdata = 16'h0000;
      endcase
      for (int a = 0; a < 4; a++) begin
        if (reg_addr_i == `SDC_OFF_HOLD0 + 4'(a)) begin
          st_d.rdata = {1'b0, st_q.hold[a]};
        end
      end
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge core_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      st_q <= '0;
      st_q.lk_state <= LK_CLEAR;
      st_q.cur_sel <= `SDC_RST_CUR_SEL;
      st_q.mtype <= `SDC_RST_MOTOR_TYPE;
      st_q.hold <= {4{`SDC_RST_HOLD}};
      st_q.pwr_arm <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata_o = st_q.rdata;
  assign amp_enable_o = st_q.amp_en;
  assign hold_quarter_o = st_q.quarter;
  assign axis_current_ma_o = st_q.cur_ma;
  assign handler_launch_o = st_q.launch;

  // ========================================================================
  // checks
  sequence s_lk_trip;
    !st_q.lk_filt ##1 st_q.lk_filt;
  endsequence

  sequence s_lk_off;
    (amp_enable_o == 4'h0) ##1 (st_q.lk_state != LK_CLEAR);
  endsequence

  chk_lockout_off: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    s_lk_trip |=> s_lk_off)
    else $error("lockout did not disable the drive");

  chk_lockout_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (st_q.lk_state == LK_TRIPPED && !cmd_disable) |=> st_q.lk_state == LK_TRIPPED)
    else $error("lockout left without disable command");

  chk_query3_value: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (reg_rd_i && reg_addr_i == `SDC_OFF_QUERY3 && st_q.lk_state != LK_CLEAR)
    |=> reg_rdata_o == 16'h0003)
    else $error("lockout query did not return 3");

  chk_query_noside: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (reg_rd_i && !reg_wr_i && !pair_over[0] && !pair_over[1])
    |=> (st_q.oc == $past(st_q.oc)))
    else $error("fault read changed over-current flags");

  chk_oc_trip: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    pair_over[0] |=> (st_q.oc[0] && amp_enable_o[1:0] == 2'b00))
    else $error("pair over-current did not disable axes");

  chk_oc_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (st_q.oc[1] && !cmd_reenable) |=> st_q.oc[1])
    else $error("over-current cleared without re-enable");

  chk_uv_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    supply_low |=> (st_q.uv && amp_enable_o == 4'h0))
    else $error("under-voltage did not disable amp");

  chk_uv_recover: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (!supply_low ##1 !supply_low) |=> !st_q.uv)
    else $error("under-voltage did not recover");

  chk_launch_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    handler_launch_o |-> $past(st_q.handler_def))
    else $error("handler launched while not defined");

  chk_moving_full: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    axis_moving_i[0] |=> (!hold_quarter_o[0] && st_q.idle_cnt[0] == 15'h0000))
    else $error("holding applied while moving");

  chk_quarter_level: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (!axis_moving_i[0] && st_q.hold[0] == 15'h0001 && st_d.cur_sel[1:0] == 2'h0)
    |=> axis_current_ma_o[11:0] == 12'h07d)
    else $error("quarter current wrong at 0.5 A");

  chk_hold_wait: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (!axis_moving_i[2] && st_q.hold[2] >= 15'h0002 && st_q.idle_cnt[2] >= st_q.hold[2])
    |=> !amp_enable_o[2])
    else $error("amp enable kept after hold wait");

  // clear only once the pair has stopped overdrawing
  chk_oc_reenable: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (st_q.oc[0] && cmd_reenable && !pair_over[0])
    |=> !st_q.oc[0])
    else $error("over-current not cleared by re-enable");

  chk_lockout_rearm: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (st_q.lk_state == LK_DISARMED && cmd_reenable && !cmd_disable && !st_q.lk_filt)
    |=> (st_q.lk_state == LK_CLEAR && st_q.axis_off == 4'h0))
    else $error("lockout not recovered by re-enable");

  chk_pwrup_launch: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (st_q.pwr_arm && supply_low && st_q.handler_def)
    |=> handler_launch_o)
    else $error("power-up handler launch missing");

  chk_full_rest: assert property (@(posedge core_clk_i) disable iff (!rst_b_q)
    (!axis_moving_i[1] && st_q.hold[1] == 15'h0000 && st_d.cur_sel[3:2] == 2'h1)
    |=> (!hold_quarter_o[1] && axis_current_ma_o[23:12] == `SDC_CUR_CODE1_MA))
    else $error("resting axis lost full current");

endmodule : stepper_drive_control_fault

`default_nettype wire

// ---- core/stepper_drive_pkg.sv ----
// types shared by the stepper drive control and fault block
`default_nettype none
package stepper_drive_pkg;
  // ========================================================================
  // lockout recovery states
  typedef enum logic [2:0] {
    LK_CLEAR = 3'b001,
    LK_TRIPPED = 3'b010,
    LK_DISARMED = 3'b100
  } lockout_state_t;

  // ========================================================================
  // state of the block, apart from the two reset-release flops
  typedef struct packed {
    logic lk_s1;
    logic lk_s2;
    logic lk_s3;
    logic lk_filt;
    lockout_state_t lk_state;
    logic [7:0] cur_sel;
    logic [3:0] mtype;
    logic [3:0][14:0] hold;
    logic handler_def;
    logic [3:0] axis_off;
    logic [1:0] oc;
    logic uv;
    logic [3:0][14:0] idle_cnt;
    logic [3:0] amp_en;
    logic [3:0] quarter;
    logic [3:0][11:0] cur_ma;
    logic fault_prev;
    logic pwr_arm;
    logic launch;
    logic [15:0] rdata;
  } drive_state_t;
endpackage : stepper_drive_pkg
`default_nettype wire

// ---- core/stepper_drive_regs.svh ----
// register offsets, reset values and thresholds of the stepper drive control block
`ifndef STEPPER_DRIVE_REGS_SVH
`define STEPPER_DRIVE_REGS_SVH
// ==========================================================================
// register offsets (word index on the plain register port)
`define SDC_OFF_CUR_SEL 4'h0
`define SDC_OFF_MOTOR_TYPE 4'h1
`define SDC_OFF_HOLD0 4'h2
`define SDC_OFF_CTRL 4'h6
`define SDC_OFF_CMD 4'h7
`define SDC_OFF_QUERY0 4'h8
`define SDC_OFF_QUERY3 4'h9
`define SDC_OFF_STATUS 4'ha
// ==========================================================================
// field positions
`define SDC_CMD_DISABLE_BIT 0
`define SDC_CMD_REENABLE_BIT 1
`define SDC_CTRL_HANDLER_BIT 0
`define SDC_Q0_OC0_BIT 0
`define SDC_Q0_OC1_BIT 1
`define SDC_Q0_UV_BIT 2
// ==========================================================================
// reset values
`define SDC_RST_CUR_SEL 8'h55
`define SDC_RST_MOTOR_TYPE 4'h0
`define SDC_RST_HOLD 15'h0000
`define SDC_LOCKOUT_CODE 8'h03
// ==========================================================================
// current levels in mA and supervision thresholds
`define SDC_CUR_CODE0_MA 12'h1f4
`define SDC_CUR_CODE1_MA 12'h3e8
`define SDC_CUR_CODE2_MA 12'h7d0
`define SDC_CUR_CODE3_MA 12'hbb8
`define SDC_OC_LIMIT_DA 9'h064
`define SDC_UV_LIMIT_DV 10'h078
`endif

// ---- verification/motor_supply_model.sv ----
// behavioural motors and drive supply on the far side of the stepper drive block
`timescale 1ns/1ps
`default_nettype none

module motor_supply_model (
  input wire logic [3:0] amp_enable_i,
  input wire logic [47:0] axis_current_ma_i,
  input wire logic [1:0] short_pair_i,
  input wire logic [9:0] supply_set_dv_i,
  output logic [31:0] phase_current_da_o,
  output logic [9:0] supply_dv_o
);
  // ==========================================================================
  // winding current per axis in 0.1 A
  // a disabled amp draws nothing; a shorted pair overdraws 6 A per axis even
  // with the amp off, so a re-enable during the short must not succeed
  always_comb begin
    for (int a = 0; a < 4; a++) begin
      phase_current_da_o[8*a +: 8] = 8'h00;
      if (amp_enable_i[a]) begin
        phase_current_da_o[8*a +: 8] = 8'(axis_current_ma_i[12*a +: 12] / 12'h064);
      end
      if (short_pair_i[a/2]) begin
        phase_current_da_o[8*a +: 8] = 8'h3c;
      end
    end
  end

  // supply follows the bench setting directly
  assign supply_dv_o = supply_set_dv_i;
endmodule : motor_supply_model
`default_nettype wire

// ---- verification/tb_stepper_drive_control_fault.sv ----
// self-checking bench for the stepper drive control and fault block
`include "stepper_drive_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_stepper_drive_control_fault;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic sample_tick = 1'b0;
  logic [3:0] axis_moving = 4'h0;
  logic thread0_running = 1'b0;
  logic lockout_pin = 1'b0;
  logic [31:0] phase_current_da;
  logic [9:0] supply_dv;
  logic [1:0] short_pair = 2'b00;
  logic [9:0] supply_set_dv = 10'h000;
  logic [3:0] amp_enable;
  logic [3:0] hold_quarter;
  logic [47:0] axis_current_ma;
  logic handler_launch;
  logic [15:0] rd;
  int bad_count = 0;
  int check_count = 0;
  int launch_count = 0;

  // ==========================================================================
  // clock, design and partner
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  stepper_drive_control_fault u_stepper_drive_control_fault (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .sample_tick_i(sample_tick),
    .axis_moving_i(axis_moving), .thread0_running_i(thread0_running),
    .emergency_lockout_input_i(lockout_pin), .phase_current_da_i(phase_current_da),
    .supply_dv_i(supply_dv), .amp_enable_o(amp_enable), .hold_quarter_o(hold_quarter),
    .axis_current_ma_o(axis_current_ma), .handler_launch_o(handler_launch)
  );

  motor_supply_model u_motor_supply_model (
    .amp_enable_i(amp_enable), .axis_current_ma_i(axis_current_ma),
    .short_pair_i(short_pair), .supply_set_dv_i(supply_set_dv),
    .phase_current_da_o(phase_current_da), .supply_dv_o(supply_dv)
  );

  // handler launches are one-cycle pulses, so count them at every edge
  always @(posedge core_clk) begin
    if (handler_launch === 1'b1) launch_count++;
  end

  // ==========================================================================
  // reporting and compare tasks
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // ==========================================================================
  // register port: one-cycle strobes, read data in the following cycle only
  task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic read_check(input string what, input logic [3:0] addr, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
    check(what, 48'(exp), 48'(rd));
  endtask : read_check

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cycles

  task automatic tick();
    @(posedge core_clk);
    sample_tick <= 1'b1;
    @(posedge core_clk);
    sample_tick <= 1'b0;
  endtask : tick

  // bounded wait on the amp enables; running out ends the run
  task automatic wait_amp(input logic [3:0] exp, input int limit);
    int n;
    n = 0;
    while (amp_enable !== exp && n < limit) begin
      cycles(1);
      n++;
    end
    check("amp_enable", 48'(exp), 48'(amp_enable));
    if (amp_enable !== exp) tally_and_finish();
  endtask : wait_amp

  // ==========================================================================
  // main sequence
  initial begin
    int c;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    cycles(3);
    // powered with no drive supply yet
    check("axis_current", {4{`SDC_CUR_CODE1_MA}}, axis_current_ma);
    wait_amp(4'h0, 2);
    read_check("current_select", `SDC_OFF_CUR_SEL, 16'h0055);
    read_check("query0", `SDC_OFF_QUERY0, 16'h0004);
    read_check("unmapped", 4'hf, 16'h0000);
    c = launch_count;
    reg_write(`SDC_OFF_CTRL, 16'h0001);
    cycles(4);
    check("launch_count", 48'(c + 1), 48'(launch_count));
    supply_set_dv <= 10'h0f0;
    wait_amp(4'hf, 8);
    // one current code per axis
    reg_write(`SDC_OFF_CUR_SEL, 16'h00e4);
    cycles(2);
    check("axis_current", {`SDC_CUR_CODE3_MA, `SDC_CUR_CODE2_MA,
      `SDC_CUR_CODE1_MA, `SDC_CUR_CODE0_MA}, axis_current_ma);
    // hold settings are refused until the axis is a stepper
    reg_write(`SDC_OFF_HOLD0 + 4'h3, 16'h0002);
    read_check("hold3", `SDC_OFF_HOLD0 + 4'h3, 16'h0000);
    reg_write(`SDC_OFF_MOTOR_TYPE, 16'h000f);
    reg_write(`SDC_OFF_HOLD0, 16'h0001);
    reg_write(`SDC_OFF_HOLD0 + 4'h2, 16'h0003);
    reg_write(`SDC_OFF_HOLD0 + 4'h3, 16'h7fff);
    read_check("hold2", `SDC_OFF_HOLD0 + 4'h2, 16'h0003);
    read_check("hold3", `SDC_OFF_HOLD0 + 4'h3, 16'h7fff);
    // ticks while moving must not start any hold count
    axis_moving <= 4'hf;
    repeat (4) tick();
    cycles(2);
    check("hold_quarter", 48'h0, 48'(hold_quarter));
    axis_moving <= 4'h0;
    cycles(3);
    check("hold_quarter", 48'h1, 48'(hold_quarter));
    // axis 0 rests at a quarter of 0.5 A, the others keep full current
    check("axis_current", {`SDC_CUR_CODE3_MA, `SDC_CUR_CODE2_MA,
      `SDC_CUR_CODE1_MA, 12'h07d}, axis_current_ma);
    tick();
    tick();
    cycles(2);
    check("amp_enable", 48'hf, 48'(amp_enable));
    tick();
    cycles(2);
    check("amp_enable", 48'hb, 48'(amp_enable));
    axis_moving <= 4'hf;
    cycles(3);
    check("amp_enable", 48'hf, 48'(amp_enable));
    check("hold_quarter", 48'h0, 48'(hold_quarter));
    // over-current on each pair, handler undefined
    reg_write(`SDC_OFF_CTRL, 16'h0000);
    c = launch_count;
    for (int p = 0; p < 2; p++) begin
      short_pair <= 2'(1 << p);
      cycles(3);
      check("amp_enable", 48'(4'hf ^ (4'h3 << 2*p)), 48'(amp_enable));
      read_check("query0", `SDC_OFF_QUERY0, 16'(1 << p));
      read_check("query0", `SDC_OFF_QUERY0, 16'(1 << p));
      reg_write(`SDC_OFF_CMD, 16'h0002);
      cycles(2);
      check("amp_enable", 48'(4'hf ^ (4'h3 << 2*p)), 48'(amp_enable));
      short_pair <= 2'b00;
      cycles(3);
      read_check("query0", `SDC_OFF_QUERY0, 16'(1 << p));
      reg_write(`SDC_OFF_CMD, 16'h0002);
      wait_amp(4'hf, 4);
      read_check("query0", `SDC_OFF_QUERY0, 16'h0000);
    end
    // no handler defined, so the shutdowns above must not launch one
    check("launch_count", 48'(c), 48'(launch_count));
    // under-voltage while a program runs in thread zero
    reg_write(`SDC_OFF_CTRL, 16'h0001);
    thread0_running <= 1'b1;
    c = launch_count;
    supply_set_dv <= 10'h077;
    wait_amp(4'h0, 3);
    read_check("query0", `SDC_OFF_QUERY0, 16'h0004);
    check("launch_count", 48'(c + 1), 48'(launch_count));
    supply_set_dv <= 10'h078;
    wait_amp(4'hf, 4);
    read_check("query0", `SDC_OFF_QUERY0, 16'h0000);
    // lockout, a premature re-enable, then disable and re-enable
    c = launch_count;
    lockout_pin <= 1'b1; // every axis shuts off on the lockout here
    wait_amp(4'h0, 10);
    read_check("query3", `SDC_OFF_QUERY3, 16'h0003);
    read_check("status", `SDC_OFF_STATUS, 16'h00f0);
    check("launch_count", 48'(c + 1), 48'(launch_count));
    lockout_pin <= 1'b0;
    cycles(6);
    reg_write(`SDC_OFF_CMD, 16'h0002);
    cycles(2);
    check("amp_enable", 48'h0, 48'(amp_enable));
    read_check("query3", `SDC_OFF_QUERY3, 16'h0003);
    reg_write(`SDC_OFF_CMD, 16'h0001);
    reg_write(`SDC_OFF_CMD, 16'h0002);
    wait_amp(4'hf, 4);
    read_check("status", `SDC_OFF_STATUS, 16'h000f);
    read_check("query3", `SDC_OFF_QUERY3, 16'h0000);
    read_check("cmd", `SDC_OFF_CMD, 16'h0000);
    tally_and_finish();
  end
endmodule : tb_stepper_drive_control_fault
`default_nettype wire
